// ### logic/mbrs_handler.sv
// register-read request handler: frame receive, check, response build
`timescale 1ns/1ps
`default_nettype none
`include "mbrs_params.svh"

module mbrs_handler (
  input wire logic CLK_IN, // system clock, 20 MHz
  input wire logic RST_IN, // asynchronous reset, active high
  input wire logic [7:0] SLAVE_ADDR_IN, // own slave address
  input wire logic RX_VALID_IN, // request byte valid
  input wire logic [7:0] RX_DATA_IN, // request byte
  input wire logic RX_LAST_IN, // last byte of the frame
  output logic RX_READY_OUT, // request byte taken
  output logic MEM_REQ_OUT, // register fetch strobe
  output logic [15:0] MEM_ADDR_OUT, // register word index
  input wire logic MEM_ACK_IN, // fetch data valid
  input wire logic [15:0] MEM_DATA_IN, // fetched word
  input wire logic MEM_ERR_IN, // fetch failed or address unmapped
  input wire logic MEM_FAIL_IN, // register store internal failure
  output logic PASS_OUT, // non-read frame handed on, one cycle
  output logic [7:0] PASS_FC_OUT, // function of the handed-on frame
  output logic TX_VALID_OUT, // response byte valid
  output logic [7:0] TX_DATA_OUT, // response byte
  output logic TX_LAST_OUT, // last response byte
  input wire logic TX_READY_IN // receiver takes byte
);
  mbrs_pkg::mbrs_state_e state;
  logic [7:0] hdr [0:7];
  logic [3:0] rx_cnt;
  logic rx_over;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [15:0] word;
  logic [15:0] qty_left;
  logic [15:0] fetch_addr;
  logic [7:0] tx_idx;
  logic [7:0] tx_len;
  logic [7:0] exc;
  logic hi_phase;
  logic [7:0] byte_out;
  logic push;
  logic buf_ready;
  mbrs_pkg::mbrs_byte_s buf_q [0:1];
  logic [1:0] buf_cnt;
  logic buf_head;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic known_fc(input logic [7:0] f);
    return f == `MBRS_FC_RD_HOLD || f == `MBRS_FC_RD_INP || f == `MBRS_FC_WR_ONE ||
      f == `MBRS_FC_WR_MULTI || f == `MBRS_FC_DIAG || f == `MBRS_FC_FILE || f == `MBRS_FC_SPECIAL;
  endfunction

  function automatic logic is_read(input logic [7:0] f);
    return f == `MBRS_FC_RD_HOLD || f == `MBRS_FC_RD_INP;
  endfunction

  wire logic [15:0] req_addr = {hdr[2], hdr[3]};
  wire logic [15:0] req_qty = {hdr[4], hdr[5]};
  wire logic for_me = hdr[0] == SLAVE_ADDR_IN && hdr[0] != `MBRS_BCAST_ADDR;
  wire logic bcast = hdr[0] == `MBRS_BCAST_ADDR;
  wire logic crc_ok = rx_crc == 16'h0000;
  wire logic [16:0] span_end = {1'b0, req_addr} + {1'b0, req_qty} - 17'h00001;

  assign RX_READY_OUT = state == mbrs_pkg::ST_RX;

  // frame capture; bytes past the header still feed the check
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_cnt <= 4'h0;
      rx_over <= 1'b0;
      rx_crc <= `MBRS_CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        hdr[i] <= 8'h00;
      end
    end else if (state == mbrs_pkg::ST_RX && RX_VALID_IN) begin
      rx_crc <= crc_step(rx_crc, RX_DATA_IN);
      if (rx_cnt < `MBRS_REQ_LEN) begin
        hdr[rx_cnt[2:0]] <= RX_DATA_IN;
        rx_cnt <= rx_cnt + 4'h1;
      end else begin
        rx_over <= 1'b1;
      end
    end else if (state == mbrs_pkg::ST_CHECK) begin
      rx_cnt <= 4'h0;
      rx_over <= 1'b0;
      rx_crc <= `MBRS_CRC_INIT;
    end
  end

  // main sequence
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= mbrs_pkg::ST_RX;
      exc <= 8'h00;
      tx_len <= 8'h00;
      qty_left <= 16'h0000;
      fetch_addr <= 16'h0000;
      PASS_OUT <= 1'b0;
      PASS_FC_OUT <= 8'h00;
    end else begin
      PASS_OUT <= 1'b0;
      unique case (state)
        mbrs_pkg::ST_RX: begin
          if (RX_VALID_IN && RX_LAST_IN) begin
            state <= mbrs_pkg::ST_CHECK;
          end
        end
        mbrs_pkg::ST_CHECK: begin
          state <= mbrs_pkg::ST_RX;
          if (crc_ok && rx_cnt >= 4'h4) begin
            if (!known_fc(hdr[1])) begin
              if (for_me) begin
                exc <= `MBRS_EXC_FUNC;
                tx_len <= `MBRS_EXC_LEN;
                state <= mbrs_pkg::ST_SEND;
              end
            end else if (is_read(hdr[1])) begin
              if (for_me && (rx_cnt != `MBRS_REQ_LEN || rx_over)) begin
                exc <= `MBRS_EXC_VALUE;
                tx_len <= `MBRS_EXC_LEN;
                state <= mbrs_pkg::ST_SEND;
              end else if (for_me && (req_qty < `MBRS_QTY_MIN || req_qty > `MBRS_QTY_MAX_RD)) begin
                exc <= `MBRS_EXC_VALUE;
                tx_len <= `MBRS_EXC_LEN;
                state <= mbrs_pkg::ST_SEND;
              end else if (for_me && span_end[16]) begin
                exc <= `MBRS_EXC_ADDR;
                tx_len <= `MBRS_EXC_LEN;
                state <= mbrs_pkg::ST_SEND;
              end else if (for_me) begin
                exc <= 8'h00;
                tx_len <= `MBRS_HDR_LEN + req_qty[6:0] * 8'h02 + `MBRS_CRC_LEN;
                qty_left <= req_qty;
                fetch_addr <= req_addr;
                state <= mbrs_pkg::ST_FETCH;
              end
            end else if (for_me || (bcast && (hdr[1] == `MBRS_FC_WR_ONE || hdr[1] == `MBRS_FC_WR_MULTI))) begin
              PASS_OUT <= 1'b1;
              PASS_FC_OUT <= hdr[1];
            end
          end
        end
        mbrs_pkg::ST_FETCH: begin
          state <= mbrs_pkg::ST_WAIT;
        end
        mbrs_pkg::ST_WAIT: begin
          if (MEM_ACK_IN) begin
            state <= mbrs_pkg::ST_SEND;
            qty_left <= qty_left - 16'h0001;
            fetch_addr <= fetch_addr + 16'h0001;
            if (tx_idx == 8'h00 && (MEM_ERR_IN || MEM_FAIL_IN)) begin
              exc <= MEM_FAIL_IN ? `MBRS_EXC_FAIL : `MBRS_EXC_ADDR;
              tx_len <= `MBRS_EXC_LEN;
            end
          end
        end
        mbrs_pkg::ST_SEND: begin
          if (push && tx_idx == tx_len - `MBRS_CRC_LEN - 8'h01) begin
            state <= mbrs_pkg::ST_CRC_LO;
          end else if (push && exc == 8'h00 && tx_idx >= `MBRS_HDR_LEN && !hi_phase && qty_left != 16'h0000) begin
            state <= mbrs_pkg::ST_FETCH;
          end
        end
        mbrs_pkg::ST_CRC_LO: begin
          if (push) begin
            state <= mbrs_pkg::ST_CRC_HI;
          end
        end
        mbrs_pkg::ST_CRC_HI: begin
          if (push) begin
            state <= mbrs_pkg::ST_RX;
          end
        end
        default: begin
          state <= mbrs_pkg::ST_RX;
        end
      endcase
    end
  end

  // register fetch strobe, one cycle per word
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      MEM_REQ_OUT <= 1'b0;
      MEM_ADDR_OUT <= 16'h0000;
    end else begin
      MEM_REQ_OUT <= state == mbrs_pkg::ST_FETCH;
      if (state == mbrs_pkg::ST_FETCH) begin
        MEM_ADDR_OUT <= fetch_addr;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      word <= 16'h0000;
    end else if (state == mbrs_pkg::ST_WAIT && MEM_ACK_IN) begin
      word <= MEM_DATA_IN;
    end
  end

  // response byte selection
  always_comb begin
    byte_out = 8'h00;
    unique case (state)
      mbrs_pkg::ST_CRC_LO: byte_out = tx_crc[7:0];
      mbrs_pkg::ST_CRC_HI: byte_out = tx_crc[15:8];
      default: begin
        if (tx_idx == 8'h00) begin
          byte_out = hdr[0];
        end else if (tx_idx == 8'h01) begin
          byte_out = exc != 8'h00 ? (hdr[1] | `MBRS_EXC_BIT) : hdr[1];
        end else if (tx_idx == 8'h02) begin
          byte_out = exc != 8'h00 ? exc : tx_len - `MBRS_HDR_LEN - `MBRS_CRC_LEN;
        end else begin
          byte_out = hi_phase ? word[15:8] : word[7:0];
        end
      end
    endcase
  end

  wire logic sending = state == mbrs_pkg::ST_SEND || state == mbrs_pkg::ST_CRC_LO || state == mbrs_pkg::ST_CRC_HI;
  assign push = sending && buf_ready;

  // byte position, crc and high/low phase of the outgoing frame
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_idx <= 8'h00;
      tx_crc <= `MBRS_CRC_INIT;
      hi_phase <= 1'b1;
    end else if (state == mbrs_pkg::ST_CHECK) begin
      tx_idx <= 8'h00;
      tx_crc <= `MBRS_CRC_INIT;
      hi_phase <= 1'b1;
    end else if (push && state == mbrs_pkg::ST_SEND) begin
      tx_idx <= tx_idx + 8'h01;
      tx_crc <= crc_step(tx_crc, byte_out);
      if (tx_idx >= `MBRS_HDR_LEN) begin
        hi_phase <= !hi_phase;
      end
    end
  end

  // two-entry output buffer so a stalled receiver loses nothing
  assign buf_ready = buf_cnt != 2'h2 && !(state == mbrs_pkg::ST_SEND && tx_idx == 8'h00 && buf_cnt != 2'h0);
  wire logic pop = buf_cnt != 2'h0 && (!TX_VALID_OUT || TX_READY_IN);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      buf_cnt <= 2'h0;
      buf_head <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (push) begin
        buf_q[buf_head ^ buf_cnt[0]] <= '{data: byte_out, last: state == mbrs_pkg::ST_CRC_HI};
      end
      if (pop) begin
        buf_head <= !buf_head;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TX_VALID_OUT <= 1'b0;
      TX_DATA_OUT <= 8'h00;
      TX_LAST_OUT <= 1'b0;
    end else if (!TX_VALID_OUT || TX_READY_IN) begin
      // output stage refills from the head only when empty or its byte is taken
      TX_VALID_OUT <= buf_cnt != 2'h0;
      if (buf_cnt != 2'h0) begin
        TX_DATA_OUT <= buf_q[buf_head].data;
        TX_LAST_OUT <= buf_q[buf_head].last;
      end
    end
  end

  bad_frame_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_CHECK && !crc_ok |=> state == mbrs_pkg::ST_RX)
    else $error("bad check word led to a response");
  idle_quiet_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_RX && buf_cnt == 2'h0 && !(TX_VALID_OUT && !TX_READY_IN) |=> !TX_VALID_OUT)
    else $error("byte sent without a query");
  qty_range_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_CHECK && crc_ok && for_me && is_read(hdr[1]) && req_qty > `MBRS_QTY_MAX_RD
    |=> exc == `MBRS_EXC_VALUE)
    else $error("quantity above limit not refused");
  unknown_fc_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_CHECK && crc_ok && rx_cnt >= 4'h4 && for_me && !known_fc(hdr[1])
    |=> exc == `MBRS_EXC_FUNC && state == mbrs_pkg::ST_SEND)
    else $error("unsupported function not refused");
  other_addr_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_CHECK && !for_me |=> state == mbrs_pkg::ST_RX)
    else $error("answered a frame not addressed here");
  exc_flag_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    push && state == mbrs_pkg::ST_SEND && tx_idx == 8'h01 && exc != 8'h00 |-> byte_out[7])
    else $error("exception function without bit 7");
  count_byte_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    push && state == mbrs_pkg::ST_SEND && tx_idx == 8'h02 && exc == 8'h00
    |-> byte_out == {req_qty[6:0], 1'b0})
    else $error("byte count not twice the quantity");
  fetch_addr_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_FETCH |=> MEM_REQ_OUT && MEM_ADDR_OUT == $past(fetch_addr))
    else $error("fetch address wrong");
  bcast_pass_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == mbrs_pkg::ST_CHECK && crc_ok && rx_cnt >= 4'h4 && bcast && hdr[1] == `MBRS_FC_WR_ONE |=> PASS_OUT)
    else $error("broadcast write not handed on");
endmodule
`default_nettype wire

// ### include/mbrs_params.svh
// constants for the register-read request handler
`ifndef MBRS_PARAMS_SVH
`define MBRS_PARAMS_SVH
`define MBRS_FC_RD_HOLD 8'h03
`define MBRS_FC_RD_INP 8'h04
`define MBRS_FC_WR_ONE 8'h06
`define MBRS_FC_DIAG 8'h08
`define MBRS_FC_WR_MULTI 8'h10
`define MBRS_FC_FILE 8'h14
`define MBRS_FC_SPECIAL 8'h42
`define MBRS_EXC_BIT 8'h80
`define MBRS_EXC_FUNC 8'h01
`define MBRS_EXC_ADDR 8'h02
`define MBRS_EXC_VALUE 8'h03
`define MBRS_EXC_FAIL 8'h04
`define MBRS_BCAST_ADDR 8'h00
`define MBRS_QTY_MIN 16'h0001
`define MBRS_QTY_MAX_RD 16'h007D
`define MBRS_QTY_MAX_WR 16'h0078
`define MBRS_CRC_INIT 16'hFFFF
`define MBRS_CRC_POLY 16'hA001
`define MBRS_REQ_LEN 4'h8
`define MBRS_EXC_LEN 8'h05
`define MBRS_HDR_LEN 8'h03
`define MBRS_CRC_LEN 8'h02
`endif

// ### include/mbrs_pkg.sv
// types for the register-read request handler
package mbrs_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mbrs_byte_s;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
  } mbrs_mem_req_s;
  typedef enum logic [2:0] {
    ST_RX, ST_CHECK, ST_FETCH, ST_WAIT, ST_SEND, ST_CRC_LO, ST_CRC_HI
  } mbrs_state_e;
endpackage

// ### test/mbrs_store_model.sv
// behavioural register store answering the handler's fetch strobes
`timescale 1ns/1ps
`default_nettype none
module mbrs_store_model (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // asynchronous reset, active high
  input wire logic req_in, // fetch strobe
  input wire logic [15:0] addr_in, // word index
  input wire logic fail_en_in, // report an internal failure
  output logic ack_out, // fetch answer, one cycle
  output logic [15:0] data_out, // fetched word
  output logic err_out, // unmapped word
  output logic fail_out // store failure
);
  logic busy;
  logic [15:0] addr_q;
  logic [1:0] wait_cnt;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      addr_q <= 16'h0000;
      wait_cnt <= 2'h0;
      ack_out <= 1'b0;
      data_out <= 16'h0000;
      err_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      // outside an answer the lines carry noise so a stale sample is caught
      data_out <= 16'($urandom);
      err_out <= 1'($urandom);
      fail_out <= 1'($urandom);
      if (req_in) begin
        busy <= 1'b1;
        addr_q <= addr_in;
        wait_cnt <= 2'($urandom_range(0, 3));
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
        ack_out <= 1'b1;
        data_out <= addr_q ^ 16'h5A3C;
        err_out <= (addr_q[15:12] == 4'hE);
        fail_out <= fail_en_in;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_modbus_register_read_slave.sv
// self-checking bench for the register-read request handler
`timescale 1ns/1ps
`default_nettype none
`include "mbrs_params.svh"
module tb_modbus_register_read_slave;
  logic clk_in, rst_in, rx_valid, rx_last, rx_ready, mem_req, mem_ack, mem_err, mem_fail, fail_en;
  logic pass, tx_valid, tx_last, tx_ready;
  logic [7:0] own, rx_data, pass_fc, tx_data, pf;
  logic [15:0] mem_addr, mem_data, crc, sa;
  int errors, cmp_count;
  mbrs_pkg::mbrs_byte_s exp_q[$];
  mbrs_pkg::mbrs_byte_s got;
  logic [7:0] pass_q[$];
  logic [7:0] rd_fc[2] = '{`MBRS_FC_RD_HOLD, `MBRS_FC_RD_INP};
  logic [15:0] qtys[3] = '{16'h0001, 16'h0002, `MBRS_QTY_MAX_RD};
  logic [7:0] pass_fcs[5] = '{`MBRS_FC_WR_ONE, `MBRS_FC_DIAG, `MBRS_FC_WR_MULTI, `MBRS_FC_FILE, `MBRS_FC_SPECIAL};
  mbrs_handler DUT (.CLK_IN(clk_in), .RST_IN(rst_in), .SLAVE_ADDR_IN(own), .RX_VALID_IN(rx_valid),
    .RX_DATA_IN(rx_data), .RX_LAST_IN(rx_last), .RX_READY_OUT(rx_ready), .MEM_REQ_OUT(mem_req),
    .MEM_ADDR_OUT(mem_addr), .MEM_ACK_IN(mem_ack), .MEM_DATA_IN(mem_data), .MEM_ERR_IN(mem_err),
    .MEM_FAIL_IN(mem_fail), .PASS_OUT(pass), .PASS_FC_OUT(pass_fc), .TX_VALID_OUT(tx_valid),
    .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last), .TX_READY_IN(tx_ready));
  mbrs_store_model store (.clk_in(clk_in), .rst_in(rst_in), .req_in(mem_req), .addr_in(mem_addr),
    .fail_en_in(fail_en), .ack_out(mem_ack), .data_out(mem_data), .err_out(mem_err), .fail_out(mem_fail));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ `MBRS_CRC_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic push(input logic [7:0] b, input logic last);
    exp_q.push_back(mbrs_pkg::mbrs_byte_s'{data: b, last: last});
    crc = crc_upd(crc, b);
  endtask
  task automatic push_crc;
    logic [15:0] c;
    c = crc;
    push(c[7:0], 1'b0);
    push(c[15:8], 1'b1);
  endtask
  task automatic expect_read(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] qty);
    logic [15:0] w;
    crc = `MBRS_CRC_INIT;
    push(own, 1'b0);
    push(fc, 1'b0);
    push(8'(qty << 1), 1'b0);
    for (int i = 0; i < qty; i++) begin
      w = (a + 16'(i)) ^ 16'h5A3C;
      push(w[15:8], 1'b0);
      push(w[7:0], 1'b0);
    end
    push_crc();
  endtask
  task automatic expect_exc(input logic [7:0] fc, input logic [7:0] code);
    crc = `MBRS_CRC_INIT;
    push(own, 1'b0);
    push(fc | `MBRS_EXC_BIT, 1'b0);
    push(code, 1'b0);
    push_crc();
  endtask
  // request bytes are held until the edge that takes them, check word low byte first
  task automatic send(input logic [7:0] a, fc, input logic [15:0] w1, w2, input logic bad);
    logic [7:0] b[8];
    logic [15:0] c;
    int n;
    b = '{a, fc, w1[15:8], w1[7:0], w2[15:8], w2[7:0], 8'h00, 8'h00};
    c = `MBRS_CRC_INIT;
    for (int i = 0; i < 6; i++) c = crc_upd(c, b[i]);
    b[6] = c[7:0] ^ {7'h00, bad};
    b[7] = c[15:8];
    @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      #1;
      rx_valid = 1'b1;
      rx_data = b[i];
      rx_last = (i == 7);
      n = 0;
      @(posedge clk_in);
      while (rx_ready !== 1'b1 && n < 500) begin
        n++;
        @(posedge clk_in);
      end
    end
    #1;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  endtask
  task automatic settle;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || pass_q.size() != 0) && n < 3000) begin
      n++;
      @(posedge clk_in);
    end
    check("answer complete", 16'(n < 3000), 16'h0001);
    repeat (12) @(posedge clk_in);
    #1;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // random stalls on the response side exercise the two-entry buffer
  always @(posedge clk_in) begin
    #1;
    tx_ready = ($urandom_range(0, 3) != 0);
  end
  always @(posedge clk_in) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unsolicited byte", 16'h0001, 16'h0000);
      end else begin
        got = exp_q.pop_front();
        check("tx byte", {7'h00, tx_last, tx_data}, {7'h00, got.last, got.data});
      end
    end
    if (pass === 1'b1) begin
      if (pass_q.size() == 0) begin
        check("unexpected hand-on", 16'h0001, 16'h0000);
      end else begin
        check("handed-on function", {8'h00, pass_fc}, {8'h00, pass_q.pop_front()});
      end
    end
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    check("watchdog", 16'h0001, 16'h0000);
    summarize();
  end
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b0;
    fail_en = 1'b0;
    own = 8'h11;
    rst_in = 1'b1;
    errors = 0;
    cmp_count = 0;
    void'($urandom(32'h89E6BA31));
    own = 8'($urandom_range(1, 247));
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    // both read codes on the same words must return the same data
    for (int q = 0; q < 3; q++) begin
      sa = 16'($urandom) & 16'h7FFF;
      for (int f = 0; f < 2; f++) begin
        expect_read(rd_fc[f], sa, qtys[q]);
        send(own, rd_fc[f], sa, qtys[q], 1'b0);
        settle();
      end
    end
    expect_read(`MBRS_FC_RD_HOLD, 16'hFFFF, 16'h0001);
    send(own, `MBRS_FC_RD_HOLD, 16'hFFFF, 16'h0001, 1'b0);
    settle();
    $display("test reads done");
    for (int f = 0; f < 2; f++) begin
      foreach (qtys[q]) begin
        sa = q == 0 ? 16'h0000 : 16'h007E;
        expect_exc(rd_fc[f], `MBRS_EXC_VALUE);
        send(own, rd_fc[f], 16'h0100, sa, 1'b0);
        settle();
      end
    end
    $display("test quantity limits done");
    foreach (qtys[q]) begin
      pf = q == 0 ? 8'h01 : (q == 1 ? 8'h05 : 8'h7F);
      expect_exc(pf, `MBRS_EXC_FUNC);
      send(own, pf, 16'h0000, 16'h0001, 1'b0);
      settle();
    end
    foreach (pass_fcs[k]) begin
      pass_q.push_back(pass_fcs[k]);
      send(own, pass_fcs[k], 16'h0020, 16'h0001, 1'b0);
      settle();
    end
    for (int k = 0; k < 3; k += 2) begin
      pass_q.push_back(pass_fcs[k]);
      send(`MBRS_BCAST_ADDR, pass_fcs[k], 16'h0020, 16'h0001, 1'b0);
      settle();
    end
    $display("test function codes done");
    expect_exc(`MBRS_FC_RD_INP, `MBRS_EXC_ADDR);
    send(own, `MBRS_FC_RD_INP, 16'hE000, 16'h0001, 1'b0);
    settle();
    expect_exc(`MBRS_FC_RD_HOLD, `MBRS_EXC_ADDR);
    send(own, `MBRS_FC_RD_HOLD, 16'hFFFF, 16'h0002, 1'b0);
    settle();
    fail_en = 1'b1;
    expect_exc(`MBRS_FC_RD_HOLD, `MBRS_EXC_FAIL);
    send(own, `MBRS_FC_RD_HOLD, 16'h0040, 16'h0001, 1'b0);
    settle();
    fail_en = 1'b0;
    $display("test exceptions done");
    send(own, `MBRS_FC_RD_HOLD, 16'h0010, 16'h0001, 1'b1);
    send(own ^ 8'h01, `MBRS_FC_RD_HOLD, 16'h0010, 16'h0001, 1'b0);
    send(`MBRS_BCAST_ADDR, `MBRS_FC_RD_INP, 16'h0010, 16'h0001, 1'b0);
    settle();
    expect_read(`MBRS_FC_RD_INP, 16'h0010, 16'h0002);
    send(own, `MBRS_FC_RD_INP, 16'h0010, 16'h0002, 1'b0);
    settle();
    $display("test silent frames done");
    summarize();
  end
endmodule
`default_nettype wire
